// ==== dv/pfs_pin_drv.sv ====
// external circuit driving the port pins
// assumes the bench sets the wanted levels synchronously to clk_in
`timescale 1ns/1ps

module pfs_pin_drv (
    input wire logic clk_in,
    input wire logic [7:0] level_in,
    output logic [7:0] pin_out
);
    // pins move 17 ns after the falling edge, away from the sampling edge
    initial pin_out = 8'h00;
    always @(negedge clk_in) begin
        pin_out <= #17 level_in;
    end
endmodule

// ==== dv/testbench.sv ====
// self-checking bench for the port select and pin interrupt block
// assumes pfs_pkg and pfs_port are compiled first
`timescale 1ns/1ps

module testbench;
    import pfs_pkg::*;
    logic clk_in, reset_in, wr_in, rd_in;
    logic [3:0] addr_in;
    logic [7:0] wdata_in, rdata_out, pin_in, lo_out, hi_out, vec_out;
    logic [7:0] lvl, prev, pol, en, lo, hi, t, d, exp_p;
    logic [15:0] code_out;
    logic irq_out;
    logic [31:0] seed = 32'hD6713606;
    int miscompares = 0, checks = 0, cyc = 0;

    pfs_port uut (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .pin_in(pin_in), .func_code_out(code_out),
        .func_select_lo_out(lo_out), .func_select_hi_out(hi_out),
        .pin_irq_vector_out(vec_out), .irq_out(irq_out));
    pfs_pin_drv pins (.clk_in(clk_in), .level_in(lvl), .pin_out(pin_in));

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    // vector model: lowest pending pin has priority
    function automatic logic [7:0] vec_of(logic [7:0] p);
        for (int i = 7; i >= 0; i--) begin
            if (p[i]) vec_of = 8'(2 + 2 * i);
        end
        if (p == 8'h00) vec_of = 8'h00;
    endfunction
    task automatic chk(logic [15:0] got, logic [15:0] want);
        checks++;
        if (got !== want) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] v);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, logic [7:0] want);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk(rdata_out, want);
    endtask
    task automatic complete_run();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // clock and run limit
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            complete_run();
        end
    end

    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        reset_in = 1'b1;
        {wr_in, rd_in, addr_in, wdata_in, lvl} = '0;
        repeat (8) @(posedge clk_in);
        reset_in <= 1'b0;
        rd(PFS_OFF_SEL_LO, PFS_RST_SEL);
        rd(PFS_OFF_SEL_HI, PFS_RST_SEL);
        rd(PFS_OFF_SEL_TGL, 8'h00);
        rd(PFS_OFF_IRQ_EN, PFS_RST_IRQ_EN);
        rd(4'hF, 8'h00);
        // select codes, then toggle of random pins
        for (int k = 0; k < 6; k++) begin
            lo = rnd();
            hi = rnd();
            t = rnd();
            wr(PFS_OFF_SEL_LO, lo);
            wr(PFS_OFF_SEL_HI, hi);
            // unmapped and read-only writes leave every register alone
            wr(4'hF, rnd());
            wr(PFS_OFF_IRQ_VEC, rnd());
            rd(PFS_OFF_SEL_HI, hi);
            wr(PFS_OFF_SEL_TGL, t);
            lo ^= t;
            hi ^= t;
            // let the toggle write settle before looking
            #1;
            for (int n = 0; n < 8; n++) begin
                chk(code_out[2*n+:2], {hi[n], lo[n]});
            end
            chk({hi_out, lo_out}, {hi, lo});
            rd(PFS_OFF_SEL_LO, lo);
            rd(PFS_OFF_SEL_TGL, 8'h00);
        end
        // mid-run reset returns both selects to general purpose
        @(posedge clk_in);
        reset_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        rd(PFS_OFF_SEL_LO, PFS_RST_SEL);
        rd(PFS_OFF_SEL_HI, PFS_RST_SEL);
        chk(code_out, 16'h0000);
        // pin edges against polarity, enable and vector
        for (int k = 0; k < 12; k++) begin
            pol = rnd();
            en = rnd();
            wr(PFS_OFF_EDGE_POL, pol);
            wr(PFS_OFF_IRQ_EN, en);
            wr(PFS_OFF_IRQ_PEND, 8'h00);
            rd(PFS_OFF_EDGE_POL, pol);
            prev = lvl;
            lvl = rnd();
            repeat (6) @(posedge clk_in);
            exp_p = (lvl & ~prev & ~pol) | (~lvl & prev & pol);
            rd(PFS_OFF_IRQ_PEND, exp_p);
            rd(PFS_OFF_IRQ_VEC, vec_of(exp_p));
            chk(vec_out, vec_of(exp_p));
            chk(irq_out, |(exp_p & en));
            d = rnd();
            wr(PFS_OFF_IRQ_PEND, d);
            rd(PFS_OFF_IRQ_PEND, d);
            chk(irq_out, |(d & en));
        end
        complete_run();
    end
endmodule

// ==== logic/pfs_pkg.sv ====
// package for the port function select and pin interrupt block
// assumes a plain register port with byte-wide registers
package pfs_pkg;

    // ****************************************************************
    // register map and layout
    // ****************************************************************
    localparam int PFS_WIDTH = 8;
    localparam int PFS_ADDR_W = 4;
    localparam logic [3:0] PFS_OFF_SEL_LO = 4'h0;
    localparam logic [3:0] PFS_OFF_SEL_HI = 4'h1;
    localparam logic [3:0] PFS_OFF_SEL_TGL = 4'h2;
    localparam logic [3:0] PFS_OFF_EDGE_POL = 4'h3;
    localparam logic [3:0] PFS_OFF_IRQ_EN = 4'h4;
    localparam logic [3:0] PFS_OFF_IRQ_PEND = 4'h5;
    localparam logic [3:0] PFS_OFF_IRQ_VEC = 4'h6;
    localparam logic [7:0] PFS_RST_SEL = 8'h00;
    localparam logic [7:0] PFS_RST_IRQ_EN = 8'h00;
    // edge polarity and pending flags have no documented reset value
    localparam logic [7:0] PFS_RST_UNDEF = 8'h00;
    localparam logic [7:0] PFS_VEC_NONE = 8'h00;
    localparam logic [7:0] PFS_VEC_BASE = 8'h02;

    // ****************************************************************
    // function codes per pin
    // ****************************************************************
    localparam logic [1:0] PFS_FN_GPIO = 2'h0;
    localparam logic [1:0] PFS_FN_PRIMARY = 2'h1;
    localparam logic [1:0] PFS_FN_SECONDARY = 2'h2;
    localparam logic [1:0] PFS_FN_TERTIARY = 2'h3;

    // register bus request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pfs_bus_req_t;

    // all block state
    typedef struct packed {
        logic [7:0] sel_lo;
        logic [7:0] sel_hi;
        logic [7:0] edge_pol;
        logic [7:0] irq_en;
        logic [7:0] irq_pend;
        logic [7:0] pin_s1;
        logic [7:0] pin_s2;
        logic [7:0] pin_prev;
        logic [7:0] rdata;
    } pfs_state_t;

endpackage

// ==== logic/pfs_port.sv ====
// port function select, select toggle and pin edge interrupt logic
// assumes pins asynchronous to clk_in and a one-cycle register port
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps

module pfs_port (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [pfs_pkg::PFS_ADDR_W-1:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic [7:0] pin_in,
    output logic [15:0] func_code_out,
    output logic [7:0] func_select_lo_out,
    output logic [7:0] func_select_hi_out,
    output logic [7:0] pin_irq_vector_out,
    output logic irq_out
);
    import pfs_pkg::*;

    pfs_state_t state_reg;
    pfs_state_t state_next;
    pfs_bus_req_t bus;
    logic [7:0] edge_hit;
    logic [7:0] vec;
    logic [7:0] active;

    // ****************************************************************
    // bus request bundle
    // ****************************************************************
    assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

    // per-pin edge detect and two-bit code
    genvar g;
    generate
        for (g = 0; g < PFS_WIDTH; g++) begin : g_pin
            assign edge_hit[g] = state_reg.edge_pol[g]
                ? (state_reg.pin_prev[g] & ~state_reg.pin_s2[g])
                : (~state_reg.pin_prev[g] & state_reg.pin_s2[g]);
            // hi bit is msb of code
            assign func_code_out[2*g+1:2*g] =
                {state_reg.sel_hi[g], state_reg.sel_lo[g]};

            // code of this pin decodes to the selected function
            code_pin_a: assert property (@(posedge clk_in)
                disable iff (reset_in)
                func_code_out[2*g+:2] == (func_select_hi_out[g]
                ? (func_select_lo_out[g] ? PFS_FN_TERTIARY : PFS_FN_SECONDARY)
                : (func_select_lo_out[g] ? PFS_FN_PRIMARY : PFS_FN_GPIO)))
                else $error("pin function code wrong");
            // rising edge with polarity zero raises this pin's flag
            rise_pin_a: assert property (@(posedge clk_in)
                disable iff (reset_in)
                (!state_reg.edge_pol[g] && !state_reg.pin_prev[g]
                && state_reg.pin_s2[g]) |=> state_reg.irq_pend[g])
                else $error("rising pin edge lost");
            // falling edge with polarity one raises this pin's flag
            fall_pin_a: assert property (@(posedge clk_in)
                disable iff (reset_in)
                (state_reg.edge_pol[g] && state_reg.pin_prev[g]
                && !state_reg.pin_s2[g]) |=> state_reg.irq_pend[g])
                else $error("falling pin edge lost");
            // flag rises only by an edge or a software write
            hold_pin_a: assert property (@(posedge clk_in)
                disable iff (reset_in)
                (!state_reg.irq_pend[g] && !edge_hit[g]
                && !(wr_in && addr_in == PFS_OFF_IRQ_PEND)) |=>
                !state_reg.irq_pend[g])
                else $error("pending flag set without an edge");
            // an enabled pending pin always raises the request
            irq_pin_a: assert property (@(posedge clk_in)
                disable iff (reset_in)
                (state_reg.irq_pend[g] && state_reg.irq_en[g]) |-> irq_out)
                else $error("enabled pending pin gives no irq");
            // lowest pending pin names the vector
            vec_pin_a: assert property (@(posedge clk_in)
                disable iff (reset_in)
                (state_reg.irq_pend[g]
                && (state_reg.irq_pend << (PFS_WIDTH - g)) == 8'h00) |->
                pin_irq_vector_out == PFS_VEC_BASE + 8'(2 * g))
                else $error("vector of lowest pending pin wrong");
        end
    endgenerate

    // ****************************************************************
    // priority vector, lowest pin first
    // ****************************************************************
    always_comb begin
        vec = PFS_VEC_NONE;
        // scan downward so lowest pending pin wins
        for (int i = PFS_WIDTH - 1; i >= 0; i--) begin
            if (state_reg.irq_pend[i]) begin
                vec = PFS_VEC_BASE + 8'(2 * i);
            end
        end
    end

    assign active = state_reg.irq_pend & state_reg.irq_en;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        // two-flop pin synchroniser, then previous value
        state_next.pin_s1 = pin_in;
        state_next.pin_s2 = state_reg.pin_s1;
        state_next.pin_prev = state_reg.pin_s2;
        if (bus.wr) begin
            unique case (bus.addr)
                PFS_OFF_SEL_LO: state_next.sel_lo = bus.wdata;
                PFS_OFF_SEL_HI: state_next.sel_hi = bus.wdata;
                PFS_OFF_SEL_TGL: begin
                    // invert both bits of each marked pin
                    state_next.sel_lo = state_reg.sel_lo ^ bus.wdata;
                    state_next.sel_hi = state_reg.sel_hi ^ bus.wdata;
                end
                PFS_OFF_EDGE_POL: state_next.edge_pol = bus.wdata;
                PFS_OFF_IRQ_EN: state_next.irq_en = bus.wdata;
                PFS_OFF_IRQ_PEND: state_next.irq_pend = bus.wdata;
                default: ;
            endcase
        end
        // a new edge wins over a software clear
        state_next.irq_pend = state_next.irq_pend | edge_hit;
        // read data valid in the cycle after the strobe
        state_next.rdata = 8'h00;
        if (bus.rd) begin
            unique case (bus.addr)
                PFS_OFF_SEL_LO: state_next.rdata = state_reg.sel_lo;
                PFS_OFF_SEL_HI: state_next.rdata = state_reg.sel_hi;
                PFS_OFF_SEL_TGL: state_next.rdata = 8'h00;
                PFS_OFF_EDGE_POL: state_next.rdata = state_reg.edge_pol;
                PFS_OFF_IRQ_EN: state_next.rdata = state_reg.irq_en;
                PFS_OFF_IRQ_PEND: state_next.rdata = state_reg.irq_pend;
                PFS_OFF_IRQ_VEC: state_next.rdata = vec;
                default: state_next.rdata = 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    // polarity and pending have no defined reset: zero is loaded here
    // a pin high through reset shows as a rising edge two cycles later
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_reg.sel_lo <= PFS_RST_SEL;
            state_reg.sel_hi <= PFS_RST_SEL;
            state_reg.edge_pol <= PFS_RST_UNDEF;
            state_reg.irq_en <= PFS_RST_IRQ_EN;
            state_reg.irq_pend <= PFS_RST_UNDEF;
            state_reg.pin_s1 <= 8'h00;
            state_reg.pin_s2 <= 8'h00;
            state_reg.pin_prev <= 8'h00;
            state_reg.rdata <= 8'h00;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs
    assign rdata_out = state_reg.rdata;
    assign func_select_lo_out = state_reg.sel_lo;
    assign func_select_hi_out = state_reg.sel_hi;
    assign pin_irq_vector_out = vec;
    assign irq_out = |active;

    // ****************************************************************
    // select register checks
    // ****************************************************************
    // toggle write inverts both select bits of each marked pin
    sel_toggle_a: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (wr_in && addr_in == PFS_OFF_SEL_TGL) |=>
        func_select_lo_out == ($past(func_select_lo_out) ^ $past(wdata_in))
        && func_select_hi_out ==
        ($past(func_select_hi_out) ^ $past(wdata_in)))
        else $error("select toggle wrong");
    // plain write to the low select lands whole
    lo_write_a: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (wr_in && addr_in == PFS_OFF_SEL_LO) |=>
        func_select_lo_out == $past(wdata_in))
        else $error("low select write lost");
    // plain write to the high select lands whole
    hi_write_a: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (wr_in && addr_in == PFS_OFF_SEL_HI) |=>
        func_select_hi_out == $past(wdata_in))
        else $error("high select write lost");
    // no other write moves either select register
    sel_keep_a: assert property (@(posedge clk_in)
        disable iff (reset_in)
        !(wr_in && (addr_in == PFS_OFF_SEL_LO
        || addr_in == PFS_OFF_SEL_HI || addr_in == PFS_OFF_SEL_TGL)) |=>
        $stable(func_select_lo_out) && $stable(func_select_hi_out))
        else $error("select moved without a write");
    // held reset keeps selects and enables at zero
    sel_reset_a: assert property (@(posedge clk_in)
        (reset_in && $past(reset_in)) |->
        func_select_lo_out == PFS_RST_SEL
        && func_select_hi_out == PFS_RST_SEL
        && state_reg.irq_en == PFS_RST_IRQ_EN && !irq_out)
        else $error("reset value wrong");
    // code of pin five taken from bit five of both selects
    code_map_a: assert property (@(posedge clk_in)
        disable iff (reset_in)
        func_code_out[11:10] == {func_select_hi_out[5],
        func_select_lo_out[5]})
        else $error("function code wrong");

    // ****************************************************************
    // pin edge and pending flag checks
    // ****************************************************************
    // rising edge of pin zero sets its flag with polarity zero
    rise_sets_flag_a: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (!state_reg.edge_pol[0] && !state_reg.pin_prev[0]
        && state_reg.pin_s2[0]) |=> state_reg.irq_pend[0])
        else $error("rising edge lost");
    // falling edge of pin one sets its flag with polarity one
    fall_sets_flag_a: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (state_reg.edge_pol[1] && state_reg.pin_prev[1]
        && !state_reg.pin_s2[1]) |=> state_reg.irq_pend[1])
        else $error("falling edge lost");
    // software write of pending lands, edges excepted
    pend_write_a: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (wr_in && addr_in == PFS_OFF_IRQ_PEND) |=>
        (state_reg.irq_pend & ~$past(edge_hit)) ==
        ($past(wdata_in) & ~$past(edge_hit)))
        else $error("pending write wrong");
    // an edge in the cycle of a clear still sets the flag
    edge_wins_a: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (edge_hit != 8'h00) |=>
        (state_reg.irq_pend & $past(edge_hit)) == $past(edge_hit))
        else $error("edge lost against a write");
    // polarity register takes a write whole
    pol_write_a: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (wr_in && addr_in == PFS_OFF_EDGE_POL) |=>
        state_reg.edge_pol == $past(wdata_in))
        else $error("polarity write lost");
    // compare stage holds the synced pins of one cycle before
    sync_chain_a: assert property (@(posedge clk_in)
        disable iff (reset_in)
        state_reg.pin_prev == $past(state_reg.pin_s2))
        else $error("pin compare stage wrong");

    // ****************************************************************
    // interrupt request and vector checks
    // ****************************************************************
    // request follows pending flags gated by enables
    irq_gate_a: assert property (@(posedge clk_in)
        disable iff (reset_in)
        irq_out == |(state_reg.irq_pend & state_reg.irq_en))
        else $error("irq gating wrong");
    // no enabled pending pin, no request
    irq_low_a: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (state_reg.irq_pend & state_reg.irq_en) == 8'h00 |-> !irq_out)
        else $error("irq without enabled pending pin");
    // enable register takes a write whole
    en_write_a: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (wr_in && addr_in == PFS_OFF_IRQ_EN) |=>
        state_reg.irq_en == $past(wdata_in))
        else $error("enable write lost");
    // pin zero pending always wins the vector
    vec_value_a: assert property (@(posedge clk_in)
        disable iff (reset_in)
        state_reg.irq_pend[0] |-> pin_irq_vector_out == 8'h02)
        else $error("vector priority wrong");
    // nothing pending reads as the empty vector
    vec_none_a: assert property (@(posedge clk_in)
        disable iff (reset_in)
        state_reg.irq_pend == 8'h00 |-> pin_irq_vector_out == 8'h00)
        else $error("vector not zero");

    // ****************************************************************
    // read port checks
    // ****************************************************************
    // toggle register reads as zero
    toggle_reads_zero_a: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (rd_in && addr_in == PFS_OFF_SEL_TGL) |=> rdata_out == 8'h00)
        else $error("toggle register read not zero");
    // low select reads back what it holds
    rd_lo_a: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (rd_in && addr_in == PFS_OFF_SEL_LO) |=>
        rdata_out == $past(func_select_lo_out))
        else $error("low select read wrong");
    // high select reads back what it holds
    rd_hi_a: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (rd_in && addr_in == PFS_OFF_SEL_HI) |=>
        rdata_out == $past(func_select_hi_out))
        else $error("high select read wrong");
    // polarity reads back what it holds
    rd_pol_a: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (rd_in && addr_in == PFS_OFF_EDGE_POL) |=>
        rdata_out == $past(state_reg.edge_pol))
        else $error("polarity read wrong");
    // enables read back what they hold
    rd_en_a: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (rd_in && addr_in == PFS_OFF_IRQ_EN) |=>
        rdata_out == $past(state_reg.irq_en))
        else $error("enable read wrong");
    // pending flags read back as held
    rd_pend_a: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (rd_in && addr_in == PFS_OFF_IRQ_PEND) |=>
        rdata_out == $past(state_reg.irq_pend))
        else $error("pending read wrong");
    // vector read returns the live vector of the strobe cycle
    rd_vec_a: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (rd_in && addr_in == PFS_OFF_IRQ_VEC) |=>
        rdata_out == $past(pin_irq_vector_out))
        else $error("vector read wrong");
    // unmapped indices read as zero
    rd_unmapped_a: assert property (@(posedge clk_in)
        disable iff (reset_in)
        (rd_in && addr_in > PFS_OFF_IRQ_VEC) |=> rdata_out == 8'h00)
        else $error("unmapped read not zero");
    // read data idle at zero outside the answer cycle
    rd_idle_a: assert property (@(posedge clk_in)
        disable iff (reset_in)
        !rd_in |=> rdata_out == 8'h00)
        else $error("read data not idle");

    // main scenarios reached
    toggle_c: cover property (@(posedge clk_in)
        wr_in && addr_in == PFS_OFF_SEL_TGL && wdata_in != 8'h00);
    irq_c: cover property (@(posedge clk_in) $rose(irq_out));
    vec_read_c: cover property (@(posedge clk_in)
        rd_in && addr_in == PFS_OFF_IRQ_VEC && pin_irq_vector_out != 8'h00);
    rise_c: cover property (@(posedge clk_in)
        !state_reg.edge_pol[2] && edge_hit[2]);
    fall_c: cover property (@(posedge clk_in)
        state_reg.edge_pol[3] && edge_hit[3]);

endmodule
